// File: hdl/dbs_pkg.sv
// Constants, field positions and carriers of the debug sideband block
package dbs_pkg;
  // Cluster size, one lane per core
  localparam int NCORE  = 4;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_AUTH   = 8'h08;
  localparam logic [7:0] OFS_OSLOCK = 8'h0c;
  localparam logic [7:0] OFS_DTRRX  = 8'h10;
  localparam logic [7:0] OFS_DTRTX  = 8'h20;

  // Control fields
  localparam int F_CTRL_SECURE  = 0;
  localparam int F_CTRL_RESTART = 4;
  localparam int F_CTRL_WARMRST = 8;

  // Status fields
  localparam int F_ST_ACK     = 0;
  localparam int F_ST_RXFULL  = 4;
  localparam int F_ST_TXEMPTY = 8;
  localparam int F_ST_LOCK    = 12;
  localparam int F_ST_INRESET = 16;
  localparam int F_ST_HOLD    = 20;
  localparam int F_ST_OSLOCK  = 24;

  // Authentication fields
  localparam int F_AU_HALT  = 0;
  localparam int F_AU_OBS   = 4;
  localparam int F_AU_SWEN  = 8;
  localparam int F_AU_CATCH = 12;

  // Reset values
  localparam logic [3:0] CTRL_RST    = 4'h0;
  localparam logic [3:0] OSLOCK_RST  = 4'hf;
  localparam logic [3:0] TXEMPTY_RST = 4'hf;

  // Write and read responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Per-core sideband inputs, bit n belongs to core n
  typedef struct packed {
    logic [NCORE-1:0] inv;
    logic [NCORE-1:0] ninv;
    logic [NCORE-1:0] sinv;
    logic [NCORE-1:0] sninv;
    logic [NCORE-1:0] catch_en;
    logic [NCORE-1:0] halt_req;
    logic [NCORE-1:0] lock;
    logic [NCORE-1:0] hold;
    logic [NCORE-1:0] swen;
    logic [NCORE-1:0] ext_req;
  } dbs_in_s;

  typedef enum logic [1:0] {CORE_RESET, CORE_RUN, CORE_HALT} dbs_core_e;

  typedef struct packed {
    dbs_core_e st;
  } dbs_core_s;
endpackage

// File: hdl/dbs_sync.sv
// Two-flop synchroniser for a bundle of level inputs
`timescale 1ns/100ps
module dbs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // No reset on purpose: both stages flush while reset is held, so a held
  // core never sees a cleared hold lane when reset lifts
  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    meta_reg <= d;
    q        <= meta_reg;
  end
endmodule

// File: hdl/dbs_core.sv
// Per-core run, halt and reset sequencing under debug authentication
`timescale 1ns/100ps
module dbs_core (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic inv,
  input  wire logic ninv,
  input  wire logic sinv,
  input  wire logic sninv,
  input  wire logic secure,
  input  wire logic halt_req,
  input  wire logic ext_req,
  input  wire logic catch_en,
  input  wire logic unlock_evt,
  input  wire logic hold,
  input  wire logic restart,
  input  wire logic warm_rst,
  output logic      halted,
  output logic      in_reset,
  output logic      halt_ok,
  output logic      obs_ok
);
  dbs_pkg::dbs_core_s r;
  dbs_pkg::dbs_core_s n;
  logic               req;

  // Secure state needs the secure enable as well
  assign halt_ok = inv & (~secure | sinv);
  assign obs_ok  = ninv & (~secure | sninv);

  // Level requests; the catch only counts when enabled
  assign req = halt_req
             | ext_req
             | (unlock_evt & catch_en);

  // Warm reset request overrides every state
  always_comb begin
    n = r;
    unique case (r.st)
      dbs_pkg::CORE_RESET: if (!hold) n.st = dbs_pkg::CORE_RUN;
      dbs_pkg::CORE_RUN:   if (halt_ok && req) n.st = dbs_pkg::CORE_HALT;
      dbs_pkg::CORE_HALT:  if (restart) n.st = dbs_pkg::CORE_RUN;
      default:             n.st = dbs_pkg::CORE_RESET;
    endcase
    if (warm_rst) n.st = dbs_pkg::CORE_RESET;
  end

  // Power-up lands in reset so the hold input is honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) r <= '{st: dbs_pkg::CORE_RESET};
    else r <= n;
  end

  assign halted   = (r.st == dbs_pkg::CORE_HALT);
  assign in_reset = (r.st == dbs_pkg::CORE_RESET);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_release;
    halted ##0 restart ##0 !warm_rst;
  endsequence

  a_halt_auth: assert property ($rose(halted) |-> $past(halt_ok))
    else $error("halt entered without invasive permission");
  a_obs_secure: assert property (secure && !sninv |-> !obs_ok)
    else $error("secure observation allowed without enable");
  a_hold_reset: assert property (in_reset && hold |=> in_reset)
    else $error("core left reset while held");
  a_req_halt: assert property (!in_reset && !halted && halt_ok && halt_req
                               && !warm_rst |=> halted)
    else $error("halt request not acted on");
  a_catch_halt: assert property (r.st == dbs_pkg::CORE_RUN && halt_ok && unlock_evt
                                 && catch_en && !warm_rst |=> halted)
    else $error("unlock catch did not halt");
  a_ack_hold: assert property (halted && !restart && !warm_rst |=> halted)
    else $error("acknowledge dropped without restart");
  a_ack_release: assert property (s_release |=> !halted ##1 1'b1)
    else $error("acknowledge held after restart");
endmodule

// File: hdl/dbs_top.sv
// Debug authentication and sideband block with an AXI4-Lite register slave
// Operation
// - Each vector bit serves its own core
// - Halt only with invasive, secure needs more
// - Observation only with non-invasive enables set
// - Receive flag high while receive half full
// - Transmit flag high while transmit half empty
// - Acknowledge high once request acknowledged
// - Unlock catch enable arms unlock debug event
// - Halt request level one asks for halt
// - Lock status reported as input shows
// - Hold input keeps core in reset
// - Data channel register path needs access permit
// - External request sampled as level until acknowledged
`timescale 1ns/100ps
module dbs_top (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [dbs_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [dbs_pkg::ADDR_W-1:0] araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic [3:0]                invasive_enable_in,
  input  wire logic [3:0]                noninvasive_enable_in,
  input  wire logic [3:0]                secure_invasive_enable_in,
  input  wire logic [3:0]                secure_noninvasive_enable_in,
  input  wire logic [3:0]                os_unlock_catch_enable,
  input  wire logic [3:0]                halt_request_in,
  input  wire logic [3:0]                sw_lock_status_in,
  input  wire logic [3:0]                hold_in_warm_reset,
  input  wire logic [3:0]                sw_access_permit,
  input  wire logic [3:0]                external_halt_request,
  output logic [3:0]                     dcc_rx_full,
  output logic [3:0]                     dcc_tx_empty,
  output logic [3:0]                     halt_acknowledge,
  output logic [3:0]                     core_in_reset
);
  localparam int NC = dbs_pkg::NCORE;

  // Whole state of the slave and the channel registers
  typedef struct packed {
    logic                          aw_have;
    logic [dbs_pkg::ADDR_W-1:0]    awaddr;
    logic                          w_have;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic [NC-1:0]                 secure;
    logic [NC-1:0]                 oslock;
    logic [NC-1:0]                 rx_full;
    logic [NC-1:0]                 tx_empty;
    logic [NC-1:0][31:0]           rx_data;
    logic [NC-1:0][31:0]           tx_data;
    logic [NC-1:0]                 restart;
    logic [NC-1:0]                 warm_rst;
    logic [NC-1:0]                 unlock;
  } dbs_state_s;

  dbs_state_s       r;
  dbs_state_s       n;
  dbs_pkg::dbs_in_s in_raw;
  dbs_pkg::dbs_in_s in_s;
  logic [NC-1:0]    halted;
  logic [NC-1:0]    in_rst;
  logic [NC-1:0]    halt_ok;
  logic [NC-1:0]    obs_ok;
  logic [31:0]      status_w;
  logic [31:0]      auth_w;
  logic [31:0]      wm;
  logic [1:0]       rc;
  logic [1:0]       wc;
  logic             rd_dtr;
  logic             wr_dtr;
  logic             rd_take;
  logic             wr_go;

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction

  // Bundle the raw sideband pins, lane n is core n
  assign in_raw = '{inv:      invasive_enable_in,
                    ninv:     noninvasive_enable_in,
                    sinv:     secure_invasive_enable_in,
                    sninv:    secure_noninvasive_enable_in,
                    catch_en: os_unlock_catch_enable,
                    halt_req: halt_request_in,
                    lock:     sw_lock_status_in,
                    hold:     hold_in_warm_reset,
                    swen:     sw_access_permit,
                    ext_req:  external_halt_request};

  // Pins may change at any time relative to aclk
  dbs_sync #(
    .WIDTH ($bits(dbs_pkg::dbs_in_s))
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (in_raw),
    .q       (in_s)
  );

  // One sequencer per core, each sees only its own lane
  for (genvar i = 0; i < NC; i++) begin : g_core
    dbs_core u_core (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .inv        (in_s.inv[i]),
      .ninv       (in_s.ninv[i]),
      .sinv       (in_s.sinv[i]),
      .sninv      (in_s.sninv[i]),
      .secure     (r.secure[i]),
      .halt_req   (in_s.halt_req[i]),
      .ext_req    (in_s.ext_req[i]),
      .catch_en   (in_s.catch_en[i]),
      .unlock_evt (r.unlock[i]),
      .hold       (in_s.hold[i]),
      .restart    (r.restart[i]),
      .warm_rst   (r.warm_rst[i]),
      .halted     (halted[i]),
      .in_reset   (in_rst[i]),
      .halt_ok    (halt_ok[i]),
      .obs_ok     (obs_ok[i])
    );
  end

  // Read-only views of core state and permissions
  always_comb begin
    status_w = '0;
    status_w[dbs_pkg::F_ST_ACK     +: NC] = halted;
    status_w[dbs_pkg::F_ST_RXFULL  +: NC] = r.rx_full;
    status_w[dbs_pkg::F_ST_TXEMPTY +: NC] = r.tx_empty;
    status_w[dbs_pkg::F_ST_LOCK    +: NC] = in_s.lock;
    status_w[dbs_pkg::F_ST_INRESET +: NC] = in_rst;
    status_w[dbs_pkg::F_ST_HOLD    +: NC] = in_s.hold;
    status_w[dbs_pkg::F_ST_OSLOCK  +: NC] = r.oslock;
    auth_w = '0;
    auth_w[dbs_pkg::F_AU_HALT  +: NC] = halt_ok;
    auth_w[dbs_pkg::F_AU_OBS   +: NC] = obs_ok;
    auth_w[dbs_pkg::F_AU_SWEN  +: NC] = in_s.swen;
    auth_w[dbs_pkg::F_AU_CATCH +: NC] = in_s.catch_en;
  end

  // Channel decode shared by the logic and the checks
  assign rd_dtr  = (araddr[1:0] == 2'h0) &&
                   (araddr[7:4] == dbs_pkg::OFS_DTRRX[7:4] ||
                    araddr[7:4] == dbs_pkg::OFS_DTRTX[7:4]);
  assign wr_dtr  = (r.awaddr[1:0] == 2'h0) &&
                   (r.awaddr[7:4] == dbs_pkg::OFS_DTRRX[7:4] ||
                    r.awaddr[7:4] == dbs_pkg::OFS_DTRTX[7:4]);
  assign rc      = araddr[3:2];
  assign wc      = r.awaddr[3:2];
  assign rd_take = arvalid && arready;
  assign wr_go   = r.aw_have && r.w_have && !r.bvalid;
  assign wm      = strb_mask(r.wstrb);

  // Next state: responses, reads, captures, then writes so a write wins over a read
  always_comb begin
    n = r;
    n.restart  = '0;
    n.warm_rst = '0;
    n.unlock   = '0;
    if (r.bvalid && bready) n.bvalid = 1'b0;
    if (r.rvalid && rready) n.rvalid = 1'b0;
    // Read address taken only while no read data is pending
    if (rd_take) begin
      n.rvalid = 1'b1;
      n.rresp  = dbs_pkg::RESP_OKAY;
      n.rdata  = '0;
      if (rd_dtr) begin
        if (!in_s.swen[rc]) begin
          n.rresp = dbs_pkg::RESP_SLVERR;
        end else if (araddr[7:4] == dbs_pkg::OFS_DTRRX[7:4]) begin
          n.rdata      = r.rx_data[rc];
          n.rx_full[rc] = 1'b0;
        end else begin
          n.rdata        = r.tx_data[rc];
          n.tx_empty[rc] = 1'b1;
        end
      end else begin
        case (araddr)
          dbs_pkg::OFS_CTRL:   n.rdata[dbs_pkg::F_CTRL_SECURE +: NC] = r.secure;
          dbs_pkg::OFS_STATUS: n.rdata = status_w;
          dbs_pkg::OFS_AUTH:   n.rdata = auth_w;
          dbs_pkg::OFS_OSLOCK: n.rdata[NC-1:0] = r.oslock;
          default:             n.rresp = dbs_pkg::RESP_DECERR;
        endcase
      end
    end
    // Address and data may arrive in either order
    if (awvalid && awready) begin
      n.aw_have = 1'b1;
      n.awaddr  = awaddr;
    end
    if (wvalid && wready) begin
      n.w_have = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    // Write performed once both halves are held and no response waits
    if (wr_go) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = dbs_pkg::RESP_OKAY;
      if (wr_dtr) begin
        if (!in_s.swen[wc]) begin
          n.bresp = dbs_pkg::RESP_SLVERR;
        end else if (r.awaddr[7:4] == dbs_pkg::OFS_DTRRX[7:4]) begin
          n.rx_data[wc] = (r.rx_data[wc] & ~wm) | (r.wdata & wm);
          n.rx_full[wc] = 1'b1;
        end else begin
          n.tx_data[wc]  = (r.tx_data[wc] & ~wm) | (r.wdata & wm);
          n.tx_empty[wc] = 1'b0;
        end
      end else begin
        case (r.awaddr)
          dbs_pkg::OFS_CTRL: begin
            n.secure   = (r.secure & ~wm[dbs_pkg::F_CTRL_SECURE +: NC])
                       | (r.wdata[dbs_pkg::F_CTRL_SECURE +: NC]
                          & wm[dbs_pkg::F_CTRL_SECURE +: NC]);
            n.restart  = r.wdata[dbs_pkg::F_CTRL_RESTART +: NC]
                       & wm[dbs_pkg::F_CTRL_RESTART +: NC];
            n.warm_rst = r.wdata[dbs_pkg::F_CTRL_WARMRST +: NC]
                       & wm[dbs_pkg::F_CTRL_WARMRST +: NC];
          end
          dbs_pkg::OFS_OSLOCK: begin
            n.oslock = (r.oslock & ~wm[NC-1:0]) | (r.wdata[NC-1:0] & wm[NC-1:0]);
            n.unlock = r.oslock & ~n.oslock;
          end
          dbs_pkg::OFS_STATUS, dbs_pkg::OFS_AUTH: begin
            n.bresp = dbs_pkg::RESP_OKAY;
          end
          default: n.bresp = dbs_pkg::RESP_DECERR;
        endcase
      end
    end
  end

  // Synchronous reset; transmit halves start empty, OS lock starts set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r          <= '0;
      r.secure   <= dbs_pkg::CTRL_RST;
      r.oslock   <= dbs_pkg::OSLOCK_RST;
      r.tx_empty <= dbs_pkg::TXEMPTY_RST;
    end else begin
      r <= n;
    end
  end

  // Handshake readies follow the holding flags
  assign awready = !r.aw_have;
  assign wready  = !r.w_have;
  assign arready = !r.rvalid;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;

  // Channel flag pins come straight from state flops, acknowledge and in-reset pins from a decode of each core's state
  assign dcc_rx_full      = r.rx_full;
  assign dcc_tx_empty     = r.tx_empty;
  assign halt_acknowledge = halted;
  assign core_in_reset    = in_rst;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Raw pins reach the lanes two edges later
  a_sync_delay: assert property (##2 1'b1 |-> in_s == $past(in_raw, 2))
    else $error("sideband input not two stages late");

  // Response ties a refused channel write to its error
  sequence s_dtr_refused;
    wr_go && wr_dtr && !in_s.swen[wc];
  endsequence
  a_sw_refuse: assert property (s_dtr_refused |=>
                                bvalid && bresp == dbs_pkg::RESP_SLVERR)
    else $error("channel write not refused without permit");

  a_rd_answer: assert property (rd_take |=> rvalid)
    else $error("read answer missing");

  for (genvar i = 0; i < NC; i++) begin : g_chk
    logic rx_wr_go;
    logic tx_rd_go;
    logic st_rd;
    assign rx_wr_go = wr_go && wr_dtr && wc == 2'(i) && in_s.swen[i]
                      && r.awaddr[7:4] == dbs_pkg::OFS_DTRRX[7:4];
    assign tx_rd_go = rd_take && rd_dtr && rc == 2'(i) && in_s.swen[i]
                      && araddr[7:4] == dbs_pkg::OFS_DTRTX[7:4];
    assign st_rd    = rd_take && araddr == dbs_pkg::OFS_STATUS;

    sequence s_rx_filled;
      rx_wr_go ##1 dcc_rx_full[i];
    endsequence

    a_rx_fill: assert property (rx_wr_go |-> s_rx_filled)
      else $error("receive flag not set by fill");
    a_tx_drain: assert property (tx_rd_go && !(wr_go && wr_dtr && wc == 2'(i))
                                 |=> dcc_tx_empty[i])
      else $error("transmit flag not set by drain");
    a_lane_own: assert property ($rose(halt_acknowledge[i]) |->
                                 $past(in_s.halt_req[i] || in_s.ext_req[i]
                                       || r.unlock[i]))
      else $error("core halted by another lane");
    a_lock_report: assert property (st_rd |=>
                                    rdata[dbs_pkg::F_ST_LOCK + i]
                                    == $past(in_s.lock[i]))
      else $error("lock status misreported");
    a_ack_reset: assert property (r.warm_rst[i] |=>
                                  core_in_reset[i] && !halt_acknowledge[i])
      else $error("acknowledge shown during reset");
  end
endmodule

// File: bench/dbs_sys_model.sv
// System debug control model that raises per-core external halt requests
`timescale 1ns/100ps
module dbs_sys_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] ask,
  input  wire logic       slow,
  input  wire logic [3:0] halt_acknowledge,
  output logic      [3:0] external_halt_request
);
  logic [3:0] pend;
  logic [2:0] dly;

  // Pending requests per core, dropped only once that core acknowledges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend <= 4'h0;
      dly  <= 3'h0;
      external_halt_request <= 4'h0;
    end else begin
      pend <= (pend | ask) & ~halt_acknowledge;
      dly  <= (ask != 4'h0) ? 3'h0 : ((dly == 3'h7) ? dly : dly + 3'h1);
      // Slow mode delays the rise, mimicking a sluggish controller
      external_halt_request <= (slow && dly != 3'h7) ? 4'h0 : (pend & ~halt_acknowledge);
    end
  end
endmodule

// File: bench/dbs_top_tb_top.sv
// Testbench for the debug sideband block
`timescale 1ns/100ps
module dbs_top_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0] wstrb, inv, ninv, sinv, sninv, catch, hreq, lock, hold, swen, ext, ask;
  logic [3:0] rxf, txe, ack, inrst;
  logic [1:0] bresp, rresp;
  int failures, checks, n;

  dbs_top dbs_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .invasive_enable_in(inv), .noninvasive_enable_in(ninv),
    .secure_invasive_enable_in(sinv), .secure_noninvasive_enable_in(sninv),
    .os_unlock_catch_enable(catch), .halt_request_in(hreq), .sw_lock_status_in(lock),
    .hold_in_warm_reset(hold), .sw_access_permit(swen), .external_halt_request(ext),
    .dcc_rx_full(rxf), .dcc_tx_empty(txe), .halt_acknowledge(ack), .core_in_reset(inrst));

  dbs_sys_model dbs_sys_model_inst (.aclk(aclk), .aresetn(aresetn), .ask(ask), .slow(slow),
    .halt_acknowledge(ack), .external_halt_request(ext));

  // Clock at 20 MHz
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait guard; an exhausted bound ends the run
  task automatic guard(inout int cnt);
    cnt++;
    if (cnt > 40) begin
      failures++;
      close_out();
    end
  endtask

  // Write one word, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w;
    int c;
    aw = 0;
    w = 0;
    c = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      guard(c);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(c);
    end while (!bvalid);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask

  // Read one word and check its response code
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int c;
    c = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      guard(c);
    end while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(c);
    end while (!rvalid);
    d = rdata;
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask

  // Wait, bounded, for the acknowledge vector to reach a value
  task automatic wait_ack(input logic [3:0] e);
    for (n = 0; n < 12 && ack !== e; n++) @(posedge aclk);
    chk(32'(ack), 32'(e));
    if (ack !== e) close_out();
  endtask

  // Main sequence
  initial begin
    failures = 0;
    checks = 0;
    {awvalid, wvalid, bready, arvalid, rready, slow} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    {inv, ninv, sinv, sninv, catch, hreq, lock, swen, ask} = 36'h0;
    hold = 4'h8;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(32'(inrst), 32'h8);
    chk(32'(txe), 32'hf);
    chk(32'(rxf), 32'h0);
    // Refusals: no access permit, then an unmapped place
    wr(8'h10, 32'h1, dbs_pkg::RESP_SLVERR);
    rd(8'h40, dbs_pkg::RESP_DECERR, got);
    swen <= 4'hf;
    lock <= 4'h5;
    ninv <= 4'h7;
    catch <= 4'h2;
    repeat (4) @(posedge aclk);
    rd(dbs_pkg::OFS_STATUS, dbs_pkg::RESP_OKAY, got);
    chk(got & 32'h00fff000, 32'h00885000);
    // Data channel halves of cores 1 and 3
    wr(8'h14, 32'hcafe_0001, dbs_pkg::RESP_OKAY);
    chk(32'(rxf), 32'h2);
    rd(8'h14, dbs_pkg::RESP_OKAY, got);
    chk(got, 32'hcafe_0001);
    chk(32'(rxf), 32'h0);
    wr(8'h2c, 32'h0000_1234, dbs_pkg::RESP_OKAY);
    chk(32'(txe), 32'h7);
    rd(8'h2c, dbs_pkg::RESP_OKAY, got);
    chk(got, 32'h0000_1234);
    chk(32'(txe), 32'hf);
    // Halt request refused without invasive enable, then honoured
    hreq <= 4'h1;
    repeat (8) @(posedge aclk);
    chk(32'(ack), 32'h0);
    inv <= 4'h7;
    wait_ack(4'h1);
    hreq <= 4'h0;
    wr(dbs_pkg::OFS_CTRL, 32'h0000_0014, dbs_pkg::RESP_OKAY);
    wait_ack(4'h0);
    // Secure core 2 needs its secure invasive enable too
    slow <= 1'b1;
    ask <= 4'h4;
    @(posedge aclk);
    ask <= 4'h0;
    repeat (14) @(posedge aclk);
    chk(32'(ext), 32'h4);
    chk(32'(ack), 32'h0);
    sinv <= 4'h4;
    wait_ack(4'h4);
    repeat (2) @(posedge aclk);
    chk(32'(ext), 32'h0);
    // Permission summary with core 2 secure
    rd(dbs_pkg::OFS_AUTH, dbs_pkg::RESP_OKAY, got);
    chk(got & 32'h0000_ffff, 32'h0000_2f37);
    // Unlocking core 1 with its catch enabled halts it
    wr(dbs_pkg::OFS_OSLOCK, 32'h0000_000d, dbs_pkg::RESP_OKAY);
    wait_ack(4'h6);
    // Warm reset of halted core 1 while its hold is set, then release
    hold <= 4'ha;
    repeat (3) @(posedge aclk);
    wr(dbs_pkg::OFS_CTRL, 32'h0000_0204, dbs_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(inrst), 32'ha);
    chk(32'(ack), 32'h4);
    hold <= 4'h8;
    repeat (5) @(posedge aclk);
    chk(32'(inrst), 32'h8);
    close_out();
  end
endmodule
